// ===== rtl/dps_consts.svh
// Constants for the command status and power mode controller.
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_OP_NOP 8'h00
`define DPS_OP_GET_POWER 8'h0a
`define DPS_OP_GET_ADDR 8'h0b
`define DPS_OP_GET_PIXFMT 8'h0c
`define DPS_OP_GET_DISP 8'h0d
`define DPS_OP_GET_SIGNAL 8'h0e
`define DPS_OP_SLEEP_IN 8'h10
`define DPS_OP_SLEEP_OUT 8'h11
`define DPS_OP_PARTIAL 8'h12
`define DPS_OP_NORMAL 8'h13
`define DPS_FMT_16BPP 3'h5
`define DPS_FMT_18BPP 3'h6
`define DPS_BIT_IDLE 6
`define DPS_BIT_PARTIAL 5
`define DPS_BIT_SLEEP 4
`define DPS_BIT_NORMAL 3
`define DPS_BIT_DISP_ON 2
`define DPS_BIT_VSCROLL 7
`define DPS_BIT_INVERT 5
`define DPS_BIT_TE_EN 7
`define DPS_BIT_TE_MODE 6
`define DPS_CLK_HZ 25000000
`define DPS_ON_SEQ_MS 120
`define DPS_OFF_SEQ_US 50
`define DPS_RST_BYTE 8'h00
`endif

// ===== rtl/dps_pkg.sv
// Types shared by the command status and power mode controller.
`default_nettype none
package dps_pkg;
  // Power state, one-hot.
  typedef enum logic [3:0] {
    PWR_AWAKE = 4'b0001,
    PWR_OFF_SEQ = 4'b0010,
    PWR_SLEEP = 4'b0100,
    PWR_ON_SEQ = 4'b1000
  } dps_pwr_t;
  // Pixel format field of three bits.
  typedef logic [2:0] dps_fmt_t;
endpackage : dps_pkg
`default_nettype wire

// ===== rtl/dps_cmd_ctrl.sv
// Command interpreter for status reads and sleep, partial and normal modes.
`include "dps_consts.svh"
`default_nettype none
module dps_cmd_ctrl #(
  parameter int unsigned ON_SEQ_CYC = int'((64'd`DPS_ON_SEQ_MS * 64'd`DPS_CLK_HZ) / 64'd1000), // Power on cycles.
  parameter int unsigned OFF_SEQ_CYC = int'((64'd`DPS_OFF_SEQ_US * 64'd`DPS_CLK_HZ) / 64'd1000000), // Power off cycles.
  parameter int unsigned CNT_W = 22 // Sequence counter width.
) (
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic dc_sel, // Low for command, high for data.
  input wire logic wr_n, // Write strobe, taken on its rising edge.
  input wire logic rd_n, // Read strobe, active low.
  input wire logic [7:0] db_in, // Data lines from the host.
  output logic [7:0] db_out, // Status byte to the host.
  output logic db_oe, // High while the block drives the data lines.
  input wire logic display_timing_source, // High when the video port drives timing.
  input wire logic frame_start, // One-cycle pulse at each frame boundary.
  input wire logic idle_flag, // Idle mode state.
  input wire logic display_on_flag, // Display on state.
  input wire logic [7:0] addr_mode, // Last written address mode byte.
  input wire dps_pkg::dps_fmt_t video_fmt, // Video port pixel format.
  input wire dps_pkg::dps_fmt_t system_fmt, // System port pixel format.
  input wire logic vertical_scroll_flag, // Vertical scrolling active.
  input wire logic inversion_flag, // Display inversion active.
  input wire logic tear_output_enable, // Tearing output enabled.
  input wire logic tear_output_mode, // Tearing output mode, high for mode 2.
  output logic converter_en, // Voltage converter enable.
  output logic osc_en, // Internal oscillator enable.
  output logic scan_en, // Panel scanning enable.
  output logic seq_busy, // Power sequence running.
  output logic self_diag_start, // One-cycle pulse to start diagnostics.
  output logic partial_flag, // Partial mode in effect.
  output logic normal_display_flag, // Normal mode in effect.
  output logic sleep_state_flag, // High while in sleep mode.
  output logic scroll_disable // One-cycle pulse when partial mode begins.
);
  import dps_pkg::*;

  // A zero length sequence or one the counter cannot hold is refused.
  if (ON_SEQ_CYC < 1 || OFF_SEQ_CYC < 1 || ON_SEQ_CYC >= (1 << CNT_W) || OFF_SEQ_CYC >= (1 << CNT_W))
  begin : g_bad_param
    $error("Sequence length out of counter range.");
  end

  logic wr_n_q; // Write strobe one cycle ago.
  logic rd_n_q; // Read strobe one cycle ago.
  logic [7:0] cmd_q; // Last accepted opcode.
  logic [7:0] out_q; // Status byte being returned.
  logic oe_q; // Drive enable.
  dps_pwr_t pwr_q; // Power state.
  logic [CNT_W-1:0] cnt_q; // Sequence countdown.
  logic partial_q; // Partial mode in effect.
  logic pend_partial_q; // Partial entry waiting for a frame.
  logic pend_normal_q; // Normal entry waiting for a frame.
  logic diag_q; // Diagnostic start pulse.
  logic scroll_off_q; // Scroll disable pulse.
  logic wr_edge; // Write strobe rising edge.
  logic rd_edge; // Read strobe falling edge.
  logic cmd_take; // Command byte written.
  logic gated; // Opcode refused in video port timing.
  logic [7:0] op; // Opcode as written.
  logic [7:0] pwr_stat; // Power mode byte.
  logic [7:0] stat_byte; // Byte selected by the latched opcode.
  logic is_read; // Latched opcode is a status read.
  logic frame_ok; // Mode changes may apply now.

  assign op = db_in;
  assign wr_edge = wr_n & ~wr_n_q;
  assign rd_edge = ~rd_n & rd_n_q;
  assign cmd_take = wr_edge & ~dc_sel;
  // Commands tied to internal timing are dropped under the video port.
  // In sleep mode there is no display timing to upset, so they are served then.
  assign gated = display_timing_source & pwr_q[0] & (op == `DPS_OP_GET_SIGNAL || op == `DPS_OP_SLEEP_IN ||
                 op == `DPS_OP_SLEEP_OUT || op == `DPS_OP_PARTIAL);
  // With scanning stopped there are no frames, so pending changes apply at once.
  assign frame_ok = frame_start | ~pwr_q[0];

  // Strobe history for edge detection; inputs are already synchronous.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end
    else
    begin
      wr_n_q <= wr_n;
      rd_n_q <= rd_n;
    end
  end

  // Opcode latch; a refused opcode becomes a no-op so a later read stays quiet.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cmd_q <= `DPS_OP_NOP;
    else if (cmd_take)
      cmd_q <= gated ? `DPS_OP_NOP : op;
  end

  // Status bytes; the sleep bit reads high while sleep mode is on.
  assign pwr_stat = {1'b0, idle_flag, partial_q, ~pwr_q[0], ~partial_q, display_on_flag, 2'b00};

  // Byte chosen by the last opcode; unused bits read zero.
  always_comb
  begin
    stat_byte = `DPS_RST_BYTE;
    is_read = 1'b1;
    unique case (cmd_q)
      `DPS_OP_GET_POWER: stat_byte = pwr_stat;
      `DPS_OP_GET_ADDR: stat_byte = addr_mode;
      `DPS_OP_GET_PIXFMT: stat_byte = {1'b0, video_fmt, 1'b0, system_fmt};
      `DPS_OP_GET_DISP: stat_byte = {vertical_scroll_flag, 1'b0, inversion_flag, 5'h00};
      `DPS_OP_GET_SIGNAL: stat_byte = {tear_output_enable, tear_output_mode, 6'h00};
      default: is_read = 1'b0;
    endcase
  end

  // Read side: byte captured at the read strobe fall, released at its rise.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      out_q <= `DPS_RST_BYTE;
      oe_q <= 1'b0;
    end
    else if (rd_edge && dc_sel && is_read)
    begin
      out_q <= stat_byte;
      oe_q <= 1'b1;
    end
    else if (rd_n)
      oe_q <= 1'b0;
  end

  assign db_out = out_q;
  assign db_oe = oe_q;

  // Power state machine. The host stays quiet while a sequence runs, so
  // commands seen then are not served.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pwr_q <= PWR_SLEEP;
      cnt_q <= '0;
      diag_q <= 1'b0;
    end
    else
    begin
      diag_q <= 1'b0;
      unique case (pwr_q)
        PWR_AWAKE:
        begin
          // Exit while awake falls through with no effect.
          if (cmd_take && !gated && op == `DPS_OP_SLEEP_IN)
          begin
            pwr_q <= PWR_OFF_SEQ;
            cnt_q <= CNT_W'(OFF_SEQ_CYC - 1);
          end
        end
        PWR_OFF_SEQ:
        begin
          // Blank scan and power off; the host must not write now.
          if (cnt_q == '0)
            pwr_q <= PWR_SLEEP;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        PWR_SLEEP:
        begin
          // Only sleep exit leaves; a repeated entry is ignored.
          if (cmd_take && !gated && op == `DPS_OP_SLEEP_OUT)
          begin
            pwr_q <= PWR_ON_SEQ;
            cnt_q <= CNT_W'(ON_SEQ_CYC - 1);
          end
        end
        PWR_ON_SEQ:
        begin
          // Power on; diagnostics start once supplies are up.
          if (cnt_q == '0)
          begin
            pwr_q <= PWR_AWAKE;
            diag_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
      endcase
    end
  end

  // Scanning runs only while awake; converter and oscillator also run through sequences.
  assign scan_en = pwr_q[0];
  assign converter_en = ~pwr_q[2];
  assign osc_en = ~pwr_q[2];
  assign seq_busy = pwr_q[1] | pwr_q[3];
  assign sleep_state_flag = ~pwr_q[0];
  assign self_diag_start = diag_q;

  // Display mode: requests wait for a frame boundary so a frame is never split.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      partial_q <= 1'b0;
      pend_partial_q <= 1'b0;
      pend_normal_q <= 1'b0;
      scroll_off_q <= 1'b0;
    end
    else
    begin
      scroll_off_q <= 1'b0;
      if (cmd_take && !gated && op == `DPS_OP_PARTIAL && !partial_q)
      begin
        pend_partial_q <= 1'b1;
        pend_normal_q <= 1'b0;
      end
      else if (cmd_take && op == `DPS_OP_NORMAL && partial_q)
      begin
        pend_normal_q <= 1'b1;
        pend_partial_q <= 1'b0;
      end
      else if (frame_ok && pend_partial_q)
      begin
        partial_q <= 1'b1;
        pend_partial_q <= 1'b0;
        scroll_off_q <= 1'b1;
      end
      else if (frame_ok && pend_normal_q)
      begin
        partial_q <= 1'b0;
        pend_normal_q <= 1'b0;
      end
    end
  end

  assign partial_flag = partial_q;
  assign normal_display_flag = ~partial_q;
  assign scroll_disable = scroll_off_q;

  logic [CNT_W-1:0] off_cyc_q; // Cycles spent in the power off sequence.

  // Checker helper: counts the power off sequence so its length can be bounded
  // without a long delay range, which the tools would have to unroll.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      off_cyc_q <= '0;
    else if (pwr_q == PWR_OFF_SEQ)
      off_cyc_q <= off_cyc_q + 1'b1;
    else
      off_cyc_q <= '0;
  end

  default clocking dps_cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_power_byte: assert property (rd_edge && dc_sel && cmd_q == `DPS_OP_GET_POWER |=>
    db_oe && db_out == $past(pwr_stat) && db_out[7] == 1'b0 && db_out[1:0] == 2'b00)
    else $error("Power mode byte wrong.");
  a_addr_echo: assert property (rd_edge && dc_sel && cmd_q == `DPS_OP_GET_ADDR |=>
    db_out == $past(addr_mode))
    else $error("Address mode byte not echoed.");
  a_fmt_layout: assert property (rd_edge && dc_sel && cmd_q == `DPS_OP_GET_PIXFMT |=>
    db_out[7] == 1'b0 && db_out[3] == 1'b0 && db_out[6:4] == $past(video_fmt))
    else $error("Pixel format byte wrong.");
  a_sig_gated: assert property (cmd_take && gated && op == `DPS_OP_GET_SIGNAL |=> !is_read)
    else $error("Signal mode read served under video timing.");
  a_sleep_stop: assert property (cmd_take && !gated && op == `DPS_OP_SLEEP_IN && pwr_q == PWR_AWAKE
    |=> !scan_en && pwr_q == PWR_OFF_SEQ)
    else $error("Sleep entry did not stop the panel.");
  a_off_bound: assert property (pwr_q == PWR_OFF_SEQ |-> off_cyc_q < CNT_W'(OFF_SEQ_CYC))
    else $error("Power off sequence ran too long.");
  a_off_done: assert property (pwr_q == PWR_OFF_SEQ && off_cyc_q == CNT_W'(OFF_SEQ_CYC - 1)
    |=> pwr_q == PWR_SLEEP && !osc_en && !converter_en)
    else $error("Power off sequence did not reach sleep.");
  a_sleep_repeat: assert property (pwr_q == PWR_SLEEP && cmd_take && op == `DPS_OP_SLEEP_IN
    |=> pwr_q == PWR_SLEEP)
    else $error("Repeated sleep entry changed state.");
  a_exit_awake: assert property (pwr_q == PWR_AWAKE && cmd_take && op == `DPS_OP_SLEEP_OUT && !frame_start
    |=> pwr_q == PWR_AWAKE && $stable(partial_q))
    else $error("Sleep exit while awake had an effect.");
  a_diag_after: assert property (self_diag_start |-> pwr_q == PWR_AWAKE && $past(pwr_q) == PWR_ON_SEQ)
    else $error("Diagnostic start outside power on end.");
  a_partial_wait: assert property (pwr_q == PWR_AWAKE && pend_partial_q && !frame_start && !partial_q
    |=> !partial_q)
    else $error("Partial mode applied mid frame.");
  a_normal_wait: assert property (pwr_q == PWR_AWAKE && pend_normal_q && !frame_start && partial_q
    |=> partial_q)
    else $error("Normal mode applied mid frame.");
  a_flags_excl: assert property (partial_flag != normal_display_flag && pwr_stat[5] != pwr_stat[3])
    else $error("Partial and normal flags overlap.");
  a_scroll_off: assert property ($rose(partial_q) |-> scroll_disable)
    else $error("Scrolling not disabled on partial entry.");
  a_dm_sleep: assert property (pwr_q == PWR_AWAKE && cmd_take && display_timing_source
    && op == `DPS_OP_SLEEP_IN |=> pwr_q == PWR_AWAKE)
    else $error("Sleep entry accepted under video timing.");

  c_wake_up: cover property (pwr_q == PWR_ON_SEQ ##1 pwr_q == PWR_AWAKE);
  c_partial_in: cover property ($rose(partial_q));
  c_normal_back: cover property ($fell(partial_q));
  c_status_read: cover property (rd_edge && dc_sel && cmd_q == `DPS_OP_GET_POWER);
endmodule : dps_cmd_ctrl
`default_nettype wire

// ===== tb/dps_host_model.sv
// Host processor model that drives the controller's command strobes.
`default_nettype none
module dps_host_model (
  input wire logic clk_sys, // System clock.
  input wire logic [7:0] db_out, // Byte from the controller.
  input wire logic db_oe, // Controller drive enable.
  output logic dc_sel, // Low for command, high for data.
  output logic wr_n, // Write strobe, active low.
  output logic rd_n, // Read strobe, active low.
  output logic [7:0] db_in // Bytes toward the controller.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Strobes idle high so nothing is taken before the first command.
  initial
  begin
    dc_sel = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    db_in = 8'h00;
  end
  // Opcode goes out with select low and is held past the edge that sees the strobe high.
  task automatic write_cmd(input logic [7:0] op);
    @(posedge clk_sys);
    #1;
    dc_sel = 1'b0;
    db_in = op;
    wr_n = 1'b0;
    @(posedge clk_sys);
    #1;
    wr_n = 1'b1;
    @(posedge clk_sys);
    #1;
    db_in = ~op; // A released bus shows the inverse, so a stale opcode never looks valid.
  endtask
  // Read with select high; the byte is taken two cycles after the strobe falls.
  task automatic read_byte(output logic oe, output logic [7:0] d);
    dc_sel = 1'b1;
    rd_n = 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    oe = db_oe;
    d = db_out;
    rd_n = 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
  endtask
endmodule // dps_host_model
`default_nettype wire

// ===== tb/dcs_status_and_power_mode_control_bench.sv
// Self-checking bench for the command status and power mode controller.
`include "dps_consts.svh"
`default_nettype none
module dcs_status_and_power_mode_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dps_pkg::*;
  logic clk_sys, resetn, dc_sel, wr_n, rd_n, db_oe, display_timing_source, frame_start, rd_oe;
  logic idle_flag, display_on_flag, vertical_scroll_flag, inversion_flag, tear_output_enable;
  logic tear_output_mode, converter_en, osc_en, scan_en, seq_busy, self_diag_start, m_part;
  logic partial_flag, normal_display_flag, sleep_state_flag, scroll_disable, m_sleep;
  logic [7:0] db_in, db_out, addr_mode, rd_v;
  dps_fmt_t video_fmt, system_fmt;
  int n_mismatch, n_tests, n_diag, n_sd;
  // Short sequences keep the run small; waits below scale with them.
  dps_cmd_ctrl #(.ON_SEQ_CYC(20), .OFF_SEQ_CYC(5)) dps_cmd_ctrl_i (.clk_sys, .resetn, .dc_sel, .wr_n,
    .rd_n, .db_in, .db_out, .db_oe, .display_timing_source, .frame_start, .idle_flag, .display_on_flag,
    .addr_mode, .video_fmt, .system_fmt, .vertical_scroll_flag, .inversion_flag, .tear_output_enable,
    .tear_output_mode, .converter_en, .osc_en, .scan_en, .seq_busy, .self_diag_start, .partial_flag,
    .normal_display_flag, .sleep_state_flag, .scroll_disable);
  dps_host_model dps_host_model_i (.clk_sys, .db_out, .db_oe, .dc_sel, .wr_n, .rd_n, .db_in);
  // Clock of 40 ns.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse counters; a pulse that lasts two cycles counts twice and is caught.
  always @(posedge clk_sys)
  begin
    if (self_diag_start === 1'b1) n_diag++;
    if (scroll_disable === 1'b1) n_sd++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Frame boundary pulse of one cycle.
  task automatic frame();
    frame_start = 1'b1;
    tick(1);
    frame_start = 1'b0;
    tick(2);
  endtask
  // Bounded wait for a power sequence; the host stays quiet meanwhile.
  task automatic wait_seq();
    for (int k = 0; k < 100 && seq_busy !== 1'b0; k++) tick(1);
    check(8'(seq_busy), 8'h0);
  endtask
  // Expected byte worked out from the inputs and the bench's own mode model.
  function automatic logic [7:0] exp_byte(input logic [7:0] op);
    case (op)
      `DPS_OP_GET_POWER: exp_byte = {1'b0, idle_flag, m_part, m_sleep, ~m_part, display_on_flag, 2'h0};
      `DPS_OP_GET_ADDR: exp_byte = addr_mode;
      `DPS_OP_GET_PIXFMT: exp_byte = {1'b0, video_fmt, 1'b0, system_fmt};
      `DPS_OP_GET_DISP: exp_byte = {vertical_scroll_flag, 1'b0, inversion_flag, 5'h00};
      default: exp_byte = {tear_output_enable, tear_output_mode, 6'h00};
    endcase
  endfunction
  // Every status opcode in turn, with fresh random inputs; the first five use both pixel formats.
  task automatic rand_reads(input int n);
    logic [7:0] op;
    for (int i = 0; i < n; i++)
    begin
      op = `DPS_OP_GET_POWER + 8'(i % 5);
      {idle_flag, display_on_flag, vertical_scroll_flag, inversion_flag} = 4'($urandom);
      {tear_output_enable, tear_output_mode} = 2'($urandom);
      addr_mode = 8'($urandom);
      video_fmt = (i < 5) ? `DPS_FMT_16BPP : 3'($urandom);
      system_fmt = (i < 5) ? `DPS_FMT_18BPP : 3'($urandom);
      dps_host_model_i.write_cmd(op);
      dps_host_model_i.read_byte(rd_oe, rd_v);
      check(8'(rd_oe), 8'h01);
      check(rd_v, exp_byte(op));
    end
    $display("status reads done");
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // The sequence takes about three hundred cycles; five thousand means a hang.
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    resetn = 1'b0;
    {display_timing_source, frame_start, idle_flag, display_on_flag} = 4'h0;
    {vertical_scroll_flag, inversion_flag, tear_output_enable, tear_output_mode} = 4'h0;
    addr_mode = 8'h00;
    video_fmt = 3'h0;
    system_fmt = 3'h0;
    m_part = 1'b0;
    m_sleep = 1'b1;
    void'($urandom(22047));
    tick(8);
    resetn = 1'b1;
    check(8'({db_oe, partial_flag, normal_display_flag, sleep_state_flag}), 8'h03);
    rand_reads(10);
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_OUT);
    tick(1);
    check(8'({converter_en, osc_en, seq_busy}), 8'h07);
    wait_seq();
    m_sleep = 1'b0;
    tick(1);
    check(8'({scan_en, sleep_state_flag, n_diag[1:0]}), 8'h09);
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_OUT);
    tick(3);
    check(8'({scan_en, seq_busy, n_diag[1:0]}), 8'h09);
    $display("sleep exit done");
    dps_host_model_i.write_cmd(`DPS_OP_PARTIAL);
    tick(3);
    check(8'(partial_flag), 8'h00);
    frame();
    m_part = 1'b1;
    check(8'({partial_flag, normal_display_flag, n_sd[1:0]}), 8'h09);
    rand_reads(5);
    dps_host_model_i.write_cmd(`DPS_OP_PARTIAL);
    frame();
    check(8'({partial_flag, n_sd[1:0]}), 8'h05);
    dps_host_model_i.write_cmd(`DPS_OP_NORMAL);
    tick(3);
    check(8'(partial_flag), 8'h01);
    frame();
    m_part = 1'b0;
    check(8'({partial_flag, normal_display_flag}), 8'h01);
    dps_host_model_i.write_cmd(`DPS_OP_NORMAL);
    frame();
    check(8'({partial_flag, normal_display_flag, n_sd[1:0]}), 8'h05);
    $display("partial and normal done");
    display_timing_source = 1'b1;
    dps_host_model_i.write_cmd(`DPS_OP_GET_SIGNAL);
    dps_host_model_i.read_byte(rd_oe, rd_v);
    check(8'(rd_oe), 8'h00);
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_IN);
    tick(3);
    check(8'({seq_busy, scan_en}), 8'h01);
    dps_host_model_i.write_cmd(`DPS_OP_PARTIAL);
    frame();
    check(8'(partial_flag), 8'h00);
    display_timing_source = 1'b0;
    dps_host_model_i.write_cmd(`DPS_OP_NOP);
    dps_host_model_i.read_byte(rd_oe, rd_v);
    check(8'(rd_oe), 8'h00);
    $display("refusals done");
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_IN);
    tick(1);
    check(8'({scan_en, seq_busy, sleep_state_flag}), 8'h03);
    wait_seq();
    m_sleep = 1'b1;
    check(8'({converter_en, osc_en, scan_en}), 8'h00);
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_IN);
    tick(3);
    check(8'({seq_busy, sleep_state_flag}), 8'h01);
    rand_reads(5);
    display_timing_source = 1'b1;
    dps_host_model_i.write_cmd(`DPS_OP_GET_SIGNAL);
    dps_host_model_i.read_byte(rd_oe, rd_v);
    check(8'(rd_oe), 8'h01);
    check(rd_v, exp_byte(`DPS_OP_GET_SIGNAL));
    display_timing_source = 1'b0;
    tick(30);
    dps_host_model_i.write_cmd(`DPS_OP_SLEEP_OUT);
    wait_seq();
    check(8'({scan_en, sleep_state_flag}), 8'h02);
    $display("sleep entry done");
    give_verdict();
  end
endmodule // dcs_status_and_power_mode_control_bench
`default_nettype wire
